// *** logic/page_mmu_pkg.sv ***
// shared constants and types for the page translation and protection unit
package page_mmu_pkg;
   // ---------------------------------------------
   // register byte offsets
   // ---------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TAG = 8'h04;
   localparam logic [7:0] OFF_ZONE = 8'h08;
   localparam logic [7:0] OFF_CCFG = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_MASK = 8'h14;
   localparam logic [7:0] OFF_TIDX = 8'h18;
   localparam logic [7:0] OFF_THI = 8'h1c;
   localparam logic [7:0] OFF_TLO = 8'h20;
   localparam logic [7:0] OFF_TEXT = 8'h24;
   localparam logic [7:0] OFF_SA_W = 8'h28;
   localparam logic [7:0] OFF_SA_I = 8'h2c;
   localparam logic [7:0] OFF_SA_G = 8'h30;
   localparam logic [7:0] OFF_SA_U = 8'h34;
   localparam logic [7:0] OFF_SA_E = 8'h38;
   // ---------------------------------------------
   // field positions and widths
   // ---------------------------------------------
   localparam int EA_W = 32;
   localparam int TAG_W = 8;
   localparam int VA_W = TAG_W + EA_W;
   localparam int PN_W = 22;
   localparam int MIN_OFS = 10;
   localparam int ZONES = 16;
   localparam int REGION_LSB = 27;
   localparam int NUM_EVENTS = 4;
   localparam int EV_IMISS = 0;
   localparam int EV_DMISS = 1;
   localparam int EV_PROT = 2;
   localparam int EV_PRIV = 3;
   localparam int CTRL_IREL = 0;
   localparam int CTRL_DREL = 1;
   localparam int CCFG_DTAG = 0;
   localparam int CCFG_ITAG = 1;
   localparam int SET_LSB = 5;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] ZONE_PRIV_TLB = 2'h0;
   localparam logic [1:0] ZONE_TLB = 2'h1;
   localparam logic [1:0] ZONE_USER_TLB = 2'h2;

   typedef enum logic [2:0] {SZ_1K, SZ_4K, SZ_16K, SZ_64K, SZ_256K, SZ_1M, SZ_4M, SZ_16M} page_size_t;
   typedef enum logic [2:0] {COP_NONE, COP_DSET_INV, COP_IALL_INV, COP_ITOUCH, COP_DREAD, COP_IREAD} cache_op_t;

   // one translation entry, all three words
   typedef struct packed
   {
      logic [PN_W-1:0] epn;
      page_size_t size;
      logic valid;
      logic [TAG_W-1:0] tag;
      logic [PN_W-1:0] rpn;
      logic ex;
      logic wr;
      logic [3:0] zone;
      logic w;
      logic i;
      logic m;
      logic g;
      logic u0;
      logic e;
   } tlb_entry_t;

   // attributes handed out with every access
   typedef struct packed
   {
      logic w;
      logic i;
      logic g;
      logic u0;
      logic e;
   } mem_attr_t;
endpackage

// *** logic/page_mmu_protection.sv ***
// page translation, zone protection, storage attributes and cache maintenance
`timescale 1ns/1ps
module page_mmu_protection
   import page_mmu_pkg::*;
#(
   parameter int ENTRIES = 8
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   input wire logic req_valid,
   input wire logic req_fetch,
   input wire logic req_write,
   input wire logic req_user,
   input wire logic [EA_W-1:0] req_ea,
   output logic rsp_valid,
   output logic [EA_W-1:0] rsp_pa,
   output mem_attr_t rsp_attr,
   output logic rsp_prot_fault,
   output logic itlb_miss,
   output logic dtlb_miss,
   input wire logic cop_valid,
   input wire cache_op_t cop_kind,
   input wire logic cop_user,
   input wire logic [EA_W-1:0] cop_ea,
   output logic dc_set_inval,
   output logic [EA_W-1:0] dc_set_addr,
   output logic ic_all_inval,
   output logic ic_touch,
   output logic dc_debug_rd,
   output logic ic_debug_rd,
   output logic debug_tag_sel,
   output logic cop_priv_fault
);
   localparam int IDX_W = $clog2(ENTRIES);
   // ------------------------------------------
   // register state
   // ------------------------------------------
   logic [31:0] ctrl, zone_guard_reg, core_config_reg_a, sa_w, sa_i, sa_g, sa_u, sa_e;
   logic [TAG_W-1:0] proc_tag;
   logic [NUM_EVENTS-1:0] status, mask;
   logic [IDX_W-1:0] tidx;
   tlb_entry_t tlb [ENTRIES];
   logic wr_pend;
   logic [7:0] wr_addr;
   // ------------------------------------------
   // bus decode
   // ------------------------------------------
   wire addr_phase = hsel && htrans[1] && hready;
   wire wr_take = wr_pend;
   wire [7:0] rd_off = haddr[7:0];
   tlb_entry_t sel_ent;
   assign sel_ent = tlb[tidx];
   wire [31:0] ent_hi = {sel_ent.epn, sel_ent.size, sel_ent.valid, 6'h00};
   wire [31:0] ent_lo = {sel_ent.rpn, sel_ent.ex, sel_ent.wr, sel_ent.zone, sel_ent.w, sel_ent.i,
                         sel_ent.m, sel_ent.g};
   wire [31:0] ent_ext = {22'h000000, sel_ent.e, sel_ent.u0, sel_ent.tag};
   logic [31:0] rd_word;
   assign rd_word = (rd_off == OFF_CTRL) ? ctrl :
                    (rd_off == OFF_TAG) ? {24'h000000, proc_tag} :
                    (rd_off == OFF_ZONE) ? zone_guard_reg :
                    (rd_off == OFF_CCFG) ? core_config_reg_a :
                    (rd_off == OFF_STAT) ? {28'h0000000, status} :
                    (rd_off == OFF_MASK) ? {28'h0000000, mask} :
                    (rd_off == OFF_TIDX) ? {{(32-IDX_W){1'b0}}, tidx} :
                    (rd_off == OFF_THI) ? ent_hi :
                    (rd_off == OFF_TLO) ? ent_lo :
                    (rd_off == OFF_TEXT) ? ent_ext :
                    (rd_off == OFF_SA_W) ? sa_w :
                    (rd_off == OFF_SA_I) ? sa_i :
                    (rd_off == OFF_SA_G) ? sa_g :
                    (rd_off == OFF_SA_U) ? sa_u :
                    (rd_off == OFF_SA_E) ? sa_e : RESET_WORD; // unmapped reads zero
   // zero-wait slave: read data registered in the address phase
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= RESET_WORD;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend <= addr_phase && hwrite;
         wr_addr <= haddr[7:0];
         hrdata <= (addr_phase && !hwrite) ? rd_word : RESET_WORD;
      end
   end
   // ------------------------------------------
   // translation lookup
   // ------------------------------------------
   logic [ENTRIES-1:0] hit;
   for (genvar k = 0; k < ENTRIES; k++)
   begin : g_match
      // low page-number bits below the page size are don't care
      wire [PN_W-1:0] cmp_mask = ~((PN_W'(1) << (2 * tlb[k].size)) - PN_W'(1));
      assign hit[k] = tlb[k].valid && (tlb[k].tag == proc_tag) &&
                      (((tlb[k].epn ^ req_ea[EA_W-1:MIN_OFS]) & cmp_mask) == '0);
   end
   tlb_entry_t hit_ent;
   always_comb
   begin
      hit_ent = '0;
      for (int k = ENTRIES - 1; k >= 0; k--)
      begin
         if (hit[k])
         begin
            hit_ent = tlb[k]; // lowest index wins on double hits
         end
      end
   end
   wire [PN_W-1:0] pg_mask = ~((PN_W'(1) << (2 * hit_ent.size)) - PN_W'(1));
   wire [PN_W-1:0] phys_pn = (hit_ent.rpn & pg_mask) | (req_ea[EA_W-1:MIN_OFS] & ~pg_mask);
   wire [TAG_W+EA_W-1:0] vaddr = {proc_tag, req_ea};
   wire relocate = req_fetch ? ctrl[CTRL_IREL] : ctrl[CTRL_DREL]; // page entries are the only map
   wire any_hit = |hit;
   wire miss = relocate && !any_hit;
   // ------------------------------------------
   // protection: page bits then zone override
   // ------------------------------------------
   wire [1:0] zfield = zone_guard_reg[2 * hit_ent.zone +: 2];
   wire tlb_ok = req_fetch ? hit_ent.ex : (req_write ? hit_ent.wr : 1'b1);
   logic allowed;
   assign allowed = (zfield == ZONE_PRIV_TLB) ? (!req_user && tlb_ok) :
                    (zfield == ZONE_TLB) ? tlb_ok :
                    (zfield == ZONE_USER_TLB) ? (!req_user || tlb_ok) : 1'b1;
   wire prot = relocate && any_hit && !allowed;
   // real mode attributes per 128MB region
   wire [4:0] region = req_ea[EA_W-1:REGION_LSB];
   mem_attr_t real_attr, page_attr;
   assign real_attr = '{w: sa_w[region], i: sa_i[region], g: sa_g[region], u0: sa_u[region],
                        e: sa_e[region]};
   // coherence bit is held in the entry but never forwarded
   assign page_attr = '{w: hit_ent.w, i: hit_ent.i, g: hit_ent.g, u0: hit_ent.u0, e: hit_ent.e};
   // response registered one cycle after the request
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rsp_valid <= 1'b0;
         rsp_pa <= '0;
         rsp_attr <= '0;
         rsp_prot_fault <= 1'b0;
         itlb_miss <= 1'b0;
         dtlb_miss <= 1'b0;
      end
      else
      begin
         rsp_valid <= req_valid;
         rsp_pa <= relocate ? {phys_pn, req_ea[MIN_OFS-1:0]} : vaddr[EA_W-1:0];
         rsp_attr <= relocate ? page_attr : real_attr;
         rsp_prot_fault <= req_valid && prot;
         itlb_miss <= req_valid && miss && req_fetch;
         dtlb_miss <= req_valid && miss && !req_fetch;
      end
   end
   // ------------------------------------------
   // cache maintenance
   // ------------------------------------------
   // no lock state anywhere: replacement stays with the caches
   wire cop_priv_op = (cop_kind != COP_ITOUCH) && (cop_kind != COP_NONE);
   wire cop_bad = cop_valid && cop_user && cop_priv_op;
   wire cop_go = cop_valid && !cop_bad;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dc_set_inval <= 1'b0;
         dc_set_addr <= '0;
         ic_all_inval <= 1'b0;
         ic_touch <= 1'b0;
         dc_debug_rd <= 1'b0;
         ic_debug_rd <= 1'b0;
         debug_tag_sel <= 1'b0;
         cop_priv_fault <= 1'b0;
      end
      else
      begin
         dc_set_inval <= cop_go && (cop_kind == COP_DSET_INV);
         dc_set_addr <= {cop_ea[EA_W-1:SET_LSB], {SET_LSB{1'b0}}}; // one class per op
         ic_all_inval <= cop_go && (cop_kind == COP_IALL_INV);
         ic_touch <= cop_go && (cop_kind == COP_ITOUCH);
         dc_debug_rd <= cop_go && (cop_kind == COP_DREAD);
         ic_debug_rd <= cop_go && (cop_kind == COP_IREAD);
         debug_tag_sel <= (cop_kind == COP_IREAD) ? core_config_reg_a[CCFG_ITAG] :
                          core_config_reg_a[CCFG_DTAG];
         cop_priv_fault <= cop_bad;
      end
   end
   // ------------------------------------------
   // registers, events and interrupt
   // ------------------------------------------
   wire [NUM_EVENTS-1:0] ev = {cop_bad, req_valid && prot, req_valid && miss && !req_fetch,
                               req_valid && miss && req_fetch};
   wire [NUM_EVENTS-1:0] w1c = (wr_take && wr_addr == OFF_STAT) ? hwdata[NUM_EVENTS-1:0] : '0;
   wire [NUM_EVENTS-1:0] next_status = ev | (status & ~w1c); // a new event beats its clear
   wire [NUM_EVENTS-1:0] next_mask = (wr_take && wr_addr == OFF_MASK) ? hwdata[NUM_EVENTS-1:0] : mask; // no lag
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= RESET_WORD;
         proc_tag <= '0;
         zone_guard_reg <= RESET_WORD;
         core_config_reg_a <= RESET_WORD;
         status <= '0;
         mask <= '0;
         tidx <= '0;
         sa_w <= RESET_WORD;
         sa_i <= RESET_WORD;
         sa_g <= RESET_WORD;
         sa_u <= RESET_WORD;
         sa_e <= RESET_WORD;
         irq <= 1'b0;
      end
      else
      begin
         status <= next_status;
         irq <= |(next_status & next_mask);
         if (wr_take)
         begin
            case (wr_addr)
               OFF_CTRL: ctrl <= hwdata;
               OFF_TAG: proc_tag <= hwdata[TAG_W-1:0];
               OFF_ZONE: zone_guard_reg <= hwdata;
               OFF_CCFG: core_config_reg_a <= hwdata;
               OFF_MASK: mask <= hwdata[NUM_EVENTS-1:0];
               OFF_TIDX: tidx <= hwdata[IDX_W-1:0];
               OFF_SA_W: sa_w <= hwdata;
               OFF_SA_I: sa_i <= hwdata;
               OFF_SA_G: sa_g <= hwdata;
               OFF_SA_U: sa_u <= hwdata;
               OFF_SA_E: sa_e <= hwdata;
               default: ;
            endcase
         end
      end
   end
   // entries change only by software writes, never by an access
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int k = 0; k < ENTRIES; k++)
         begin
            tlb[k] <= '0;
         end
      end
      else if (wr_take)
      begin
         if (wr_addr == OFF_THI)
         begin
            {tlb[tidx].epn, tlb[tidx].size, tlb[tidx].valid} <= hwdata[31:6];
         end
         else if (wr_addr == OFF_TLO)
         begin
            {tlb[tidx].rpn, tlb[tidx].ex, tlb[tidx].wr, tlb[tidx].zone, tlb[tidx].w, tlb[tidx].i,
             tlb[tidx].m, tlb[tidx].g} <= hwdata;
         end
         else if (wr_addr == OFF_TEXT)
         begin
            {tlb[tidx].e, tlb[tidx].u0, tlb[tidx].tag} <= hwdata[9:0];
         end
      end
   end
   // ------------------------------------------
   // checks
   // ------------------------------------------
   imiss_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
      req_valid && req_fetch && ctrl[CTRL_IREL] && !any_hit |=> itlb_miss && !dtlb_miss)
      else $error("fetch miss not flagged");
   dmiss_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
      req_valid && !req_fetch && ctrl[CTRL_DREL] && !any_hit |=> dtlb_miss && !itlb_miss)
      else $error("data miss not flagged");
   real_pa_a: assert property (@(posedge clk) disable iff (!reset_n)
      req_valid && !relocate |=> rsp_pa == $past(req_ea) && rsp_attr == $past(real_attr))
      else $error("real mode address or attributes wrong");
   page_offset_a: assert property (@(posedge clk) disable iff (!reset_n)
      req_valid && relocate && any_hit |=> rsp_pa[MIN_OFS-1:0] == $past(req_ea[MIN_OFS-1:0]))
      else $error("page offset altered");
   zone_open_a: assert property (@(posedge clk) disable iff (!reset_n)
      req_valid && relocate && any_hit && zfield == 2'h3 |=> !rsp_prot_fault)
      else $error("open zone faulted");
   ro_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      req_valid && req_write && !req_fetch && relocate && any_hit && zfield == ZONE_TLB && !hit_ent.wr
      |=> rsp_prot_fault)
      else $error("write to read-only page allowed");
   touch_user_a: assert property (@(posedge clk) disable iff (!reset_n)
      cop_valid && cop_user && cop_kind == COP_ITOUCH |=> ic_touch && !cop_priv_fault)
      else $error("user touch refused");
   ic_inval_a: assert property (@(posedge clk) disable iff (!reset_n)
      cop_valid && !cop_user && cop_kind == COP_IALL_INV |=> ic_all_inval ##1 !ic_all_inval || $past(cop_go))
      else $error("instruction invalidate not single pulse");
   dset_inval_a: assert property (@(posedge clk) disable iff (!reset_n)
      cop_valid && !cop_user && cop_kind == COP_DSET_INV
      |=> dc_set_inval && dc_set_addr[EA_W-1:SET_LSB] == $past(cop_ea[EA_W-1:SET_LSB]))
      else $error("set invalidate wrong class");
   irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 irq == |(status & mask))
      else $error("interrupt not matching status");
endmodule // page_mmu_protection

// *** sim/core_model.sv ***
// core-side request model: one translation request per start pulse
`timescale 1ns/1ps
module core_model
   import page_mmu_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic fetch,
   input wire logic write,
   input wire logic user,
   input wire logic [EA_W-1:0] ea,
   output logic req_valid,
   output logic req_fetch,
   output logic req_write,
   output logic req_user,
   output logic [EA_W-1:0] req_ea
);
   // idle lines toggle, so a stale address never passes for a live one
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         req_valid <= 1'b0;
         req_fetch <= 1'b0;
         req_write <= 1'b0;
         req_user <= 1'b0;
         req_ea <= '0;
      end
      else
      begin
         req_valid <= start; // the core never edits entries or history
         req_fetch <= start ? fetch : ~req_fetch;
         req_write <= start ? write : ~req_write;
         req_user <= start ? user : ~req_user;
         req_ea <= start ? ea : ~req_ea;
      end
   end
endmodule // core_model

// *** sim/tb_top.sv ***
// self-checking bench for the translation and protection unit
`timescale 1ns/1ps
module tb_top;
   import page_mmu_pkg::*;
   logic clk, reset_n, hsel, hwrite, start, fetch, write, user, cop_valid, cop_user;
   logic [31:0] haddr, hwdata, ea, cop_ea, hrdata, rsp_pa, dc_set_addr, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hready;
   logic hreadyout, hresp, irq, req_valid, req_fetch, req_write, req_user;
   logic [31:0] req_ea;
   logic rsp_valid, rsp_prot_fault, itlb_miss, dtlb_miss, dc_set_inval, ic_all_inval;
   logic ic_touch, dc_debug_rd, ic_debug_rd, debug_tag_sel, cop_priv_fault;
   mem_attr_t rsp_attr;
   cache_op_t cop_kind;
   int n_fail = 0;
   int cmp_count = 0;
   localparam logic [31:0] PAGE = 32'h1234_5abc;
   assign hready = hreadyout; // single slave drives the bus ready
   page_mmu_protection #(.ENTRIES(8)) i_page_mmu_protection (.clk(clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .req_valid(req_valid),
      .req_fetch(req_fetch), .req_write(req_write), .req_user(req_user), .req_ea(req_ea),
      .rsp_valid(rsp_valid), .rsp_pa(rsp_pa), .rsp_attr(rsp_attr), .rsp_prot_fault(rsp_prot_fault),
      .itlb_miss(itlb_miss), .dtlb_miss(dtlb_miss), .cop_valid(cop_valid), .cop_kind(cop_kind),
      .cop_user(cop_user), .cop_ea(cop_ea), .dc_set_inval(dc_set_inval), .dc_set_addr(dc_set_addr),
      .ic_all_inval(ic_all_inval), .ic_touch(ic_touch), .dc_debug_rd(dc_debug_rd),
      .ic_debug_rd(ic_debug_rd), .debug_tag_sel(debug_tag_sel), .cop_priv_fault(cop_priv_fault));
   core_model i_core_model (.clk(clk), .reset_n(reset_n), .start(start), .fetch(fetch), .write(write),
      .user(user), .ea(ea), .req_valid(req_valid), .req_fetch(req_fetch), .req_write(req_write),
      .req_user(req_user), .req_ea(req_ea));
   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic print_verdict;
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy;
      do
         @(posedge clk);
      while (hready !== 1'b1);
   endtask
   // one ahb single transfer; read data taken at the data phase edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, a, wd, x);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, d);
      chk(d, exp);
   endtask
   // software owns every entry: index, then the three words
   task automatic load_entry(input logic [31:0] lo);
      wr(OFF_TIDX, 32'h0);
      wr(OFF_THI, 32'h1234_50c0);
      wr(OFF_TLO, lo);
      wr(OFF_TEXT, 32'h0000_025a);
   endtask
   // request through the core model, then wait for the answer cycle
   task automatic xl(input logic f, input logic w, input logic u, input logic [31:0] a);
      int n;
      n = 0;
      @(posedge clk);
      start <= 1'b1;
      fetch <= f;
      write <= w;
      user <= u;
      ea <= a;
      @(posedge clk);
      start <= 1'b0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (rsp_valid !== 1'b1 && n < 8);
      chk({31'h0, rsp_valid}, 32'h1);
   endtask
   // a cache op answers on the pulse outputs in the next cycle
   task automatic cop(input cache_op_t k, input logic u, input logic [31:0] a);
      @(posedge clk);
      cop_valid <= 1'b1;
      cop_kind <= k;
      cop_user <= u;
      cop_ea <= a;
      @(posedge clk);
      cop_valid <= 1'b0;
      #1;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs;
      rd_chk(OFF_STAT, 32'h0);
      rd_chk(OFF_MASK, 32'h0);
      rd_chk(8'h3c, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      chk({31'h0, hreadyout}, 32'h1);
      wr(OFF_TAG, 32'h5a);
      rd_chk(OFF_TAG, 32'h5a);
   endtask
   task automatic t_xlate;
      load_entry(32'habcd_e31b);
      wr(OFF_CTRL, 32'h3);
      xl(1'b0, 1'b0, 1'b0, PAGE);
      chk(rsp_pa, 32'habcd_eabc);
      chk({27'h0, rsp_attr}, 32'h15);
      xl(1'b1, 1'b0, 1'b0, PAGE);
      chk({31'h0, itlb_miss | rsp_prot_fault}, 32'h0);
      xl(1'b0, 1'b0, 1'b0, 32'h1234_6abc);
      chk({31'h0, dtlb_miss}, 32'h1);
      wr(OFF_TAG, 32'h5b);
      xl(1'b1, 1'b0, 1'b0, PAGE);
      chk({31'h0, itlb_miss}, 32'h1);
      wr(OFF_TAG, 32'h5a);
   endtask
   // sticky status, mask, level irq, write-one clear
   task automatic t_irq;
      rd_chk(OFF_STAT, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_MASK, 32'h2);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h1);
      wr(OFF_STAT, 32'h3);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      rd_chk(OFF_STAT, 32'h0);
   endtask
   task automatic t_prot;
      load_entry(32'habcd_e21b);
      xl(1'b0, 1'b1, 1'b0, PAGE);
      chk({31'h0, rsp_prot_fault}, 32'h1);
      xl(1'b0, 1'b0, 1'b0, PAGE);
      chk({31'h0, rsp_prot_fault}, 32'h0);
      wr(OFF_ZONE, 32'hc);
      xl(1'b0, 1'b1, 1'b0, PAGE);
      chk({31'h0, rsp_prot_fault}, 32'h0);
      wr(OFF_ZONE, 32'h0);
      xl(1'b0, 1'b0, 1'b1, PAGE);
      chk({31'h0, rsp_prot_fault}, 32'h1);
      wr(OFF_ZONE, 32'h4);
      xl(1'b0, 1'b1, 1'b0, PAGE);
      chk({31'h0, rsp_prot_fault}, 32'h1);
      wr(OFF_ZONE, 32'h8);
      xl(1'b0, 1'b1, 1'b1, PAGE);
      chk({31'h0, rsp_prot_fault}, 32'h1);
      xl(1'b0, 1'b1, 1'b0, PAGE);
      chk({31'h0, rsp_prot_fault}, 32'h0);
   endtask
   // real mode: attributes by region from the attribute registers
   task automatic t_real;
      wr(OFF_CTRL, 32'h0);
      wr(OFF_SA_W, 32'h4);
      wr(OFF_SA_E, 32'h4);
      xl(1'b0, 1'b0, 1'b0, 32'h1000_0040);
      chk(rsp_pa, 32'h1000_0040);
      chk({27'h0, rsp_attr}, 32'h11);
      xl(1'b0, 1'b0, 1'b0, 32'h1800_0040);
      chk({27'h0, rsp_attr}, 32'h0);
   endtask
   task automatic t_cop;
      cop(COP_DSET_INV, 1'b0, 32'h0000_1234);
      chk({dc_set_addr[31:1], dc_set_inval}, 32'h0000_1221);
      cop(COP_IALL_INV, 1'b0, 32'h0);
      chk({31'h0, ic_all_inval}, 32'h1);
      cop(COP_ITOUCH, 1'b1, 32'h40);
      chk({30'h0, ic_touch, cop_priv_fault}, 32'h2);
      cop(COP_DREAD, 1'b1, 32'h40);
      chk({30'h0, dc_debug_rd, cop_priv_fault}, 32'h1);
      wr(OFF_CCFG, 32'h1);
      cop(COP_DREAD, 1'b0, 32'h40);
      chk({30'h0, dc_debug_rd, debug_tag_sel}, 32'h3);
      cop(COP_IREAD, 1'b0, 32'h40);
      chk({30'h0, ic_debug_rd, debug_tag_sel}, 32'h2);
   endtask
   // ------------------------------
   // clock, reset, sequence, watchdog
   // ------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      {reset_n, hsel, hwrite, start, fetch, write, user, cop_valid, cop_user} = '0;
      {haddr, hwdata, ea, cop_ea, htrans} = '0;
      hsize = 3'h2; // whole words only
      cop_kind = COP_NONE;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_xlate();
      t_irq();
      t_prot();
      t_real();
      t_cop();
      print_verdict();
   end
   // generous bound; the sequence needs about one hundred and fifty cycles
   initial
   begin
      #400000;
      n_fail++;
      print_verdict();
   end
endmodule // tb_top
